// ===== shared/rslq_pkg.sv
// Purpose: Constants and helpers for the strength and link quality reporting block
// Assumes: 100 MHz clock, input power given as signed whole dBm
// Notes: Shared by the top module and the link quality calculator
// Overview of operation
// - Received power is expressed as a 5-bit code, 3 dB per step.
// - Code depends only on total power, never on signal type.
// - Code feeds the energy detection averaging.
// - In receive states code stays valid and refreshes every 2 us.
// - Code sits in status bits 4:0 and stays within 0 to 28.
// - Code 0 below -91 dBm; codes 1-28 are floor plus 3 dB steps.
// - Code 28 at or above -10 dBm; scale linear in dBm.
// - Status holds frame check flag bit 7, reserved 6:5; all read-only.
// - Each frame gets link quality from correlation over many symbols.
// - Link quality valid only for payloads of two octets or more.
// - Link quality is unsigned 0 to 255, higher is better.
// - Link quality is appended as one byte after the frame in the buffer.
// - Frame check flag updates with the interrupt and holds until the next.
// - Energy detection averages codes over eight symbols, 128 us.
package rslq_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int REFRESH_NS = 2000;
    localparam int REFRESH_CYC = REFRESH_NS / CLK_PERIOD_NS;
    localparam int ED_WINDOW_NS = 128000;
    localparam int ED_SAMPLES = 8;
    localparam int ED_SAMPLE_CYC = ED_WINDOW_NS / (CLK_PERIOD_NS * ED_SAMPLES);
    localparam int REFRESH_W = 8;
    localparam int ED_CNT_W = 11;
    localparam logic [5:0] STATUS_OFFSET = 6'h06;
    localparam int CRC_VALID_BIT = 7;
    localparam int CODE_MSB = 4;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic signed [8:0] FLOOR_DBM = -9'sd91;
    localparam logic signed [8:0] TOP_DBM = -9'sd10;
    localparam logic [8:0] STEP_DB = 9'h003;
    localparam logic [4:0] CODE_MAX = 5'h1C;
    localparam logic [6:0] LQI_MIN_LEN = 7'h02;
    localparam logic [7:0] LQI_INVALID = 8'h00;
    localparam int ED_AVG_SHIFT = 3;
    localparam logic [7:0] ED_DB_PER_CODE = 8'h03;

    // Total power only: no modulation information enters this mapping
    function automatic logic [4:0] strength_code(input logic signed [7:0] p_dbm);
        logic signed [8:0] p;
        logic [8:0] diff;
        p = 9'(p_dbm);
        diff = 9'(p - FLOOR_DBM);
        if (p < FLOOR_DBM) begin
            return 5'h00;
        end else if (p >= TOP_DBM) begin
            return CODE_MAX;
        end
        return 5'(diff / STEP_DB + 9'h001);
    endfunction
endpackage

// ===== shared/rslq_lqi_if.sv
// Purpose: Carrier between frame control and link quality calculator
// Assumes: One clock domain
// Notes: done is a one-cycle pulse with lqi valid alongside
`timescale 1ns/1ps
interface rslq_lqi_if;
    logic frame_start;
    logic frame_end;
    logic corr_valid;
    logic [7:0] corr;
    logic [6:0] len;
    logic done;
    logic [7:0] lqi;
    modport calc (input frame_start, frame_end, corr_valid, corr, len, output done, lqi);
    modport ctrl (output frame_start, frame_end, corr_valid, corr, len, input done, lqi);
endinterface

// ===== hw/rslq_lqi.sv
// Purpose: Per-frame link quality from symbol correlation results
// Assumes: frame_start precedes correlation samples of a frame
// Notes: Running average weighted 1/8 per symbol, seeded by the first symbol
`timescale 1ns/1ps
module rslq_lqi (
    input wire logic i_clock,
    input wire logic i_reset_n,
    rslq_lqi_if.calc lif
);
    typedef struct packed {
        logic [10:0] acc;
        logic [1:0] nsym;
        logic done;
        logic [7:0] lqi;
    } rslq_lqi_st_t;

    rslq_lqi_st_t st_reg;
    rslq_lqi_st_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (lif.frame_start) begin
            st_next.acc = 11'h000;
            st_next.nsym = 2'h0;
        end else if (lif.corr_valid) begin
            // Average over many symbols keeps one bad symbol from dominating
            if (st_reg.nsym == 2'h0) begin
                st_next.acc = {lif.corr, 3'h0};
            end else begin
                st_next.acc = 11'(st_reg.acc - (st_reg.acc >> 3) + 11'(lif.corr));
            end
            if (st_reg.nsym != 2'h3) begin
                st_next.nsym = 2'(st_reg.nsym + 2'h1);
            end
        end
        if (lif.frame_end) begin
            st_next.done = 1'b1;
            if (lif.len >= rslq_pkg::LQI_MIN_LEN) begin
                st_next.lqi = st_reg.acc[10:3];
            end else begin
                st_next.lqi = rslq_pkg::LQI_INVALID;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign lif.done = st_reg.done;
    assign lif.lqi = st_reg.lqi;

    a_lqi_short: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (lif.frame_end && lif.len < rslq_pkg::LQI_MIN_LEN) |=> (lif.done && lif.lqi == 8'h00))
        else $error("short frame produced nonzero link quality");
    a_lqi_track: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (lif.frame_start ##1 (lif.corr_valid && !lif.frame_start && !lif.frame_end))
        |=> st_reg.acc == {$past(lif.corr), 3'h0})
        else $error("first symbol did not seed the average");
endmodule // rslq_lqi

// ===== hw/rslq_top.sv
// Purpose: Strength code status register, energy averaging, link quality append
// Assumes: Frame and correlation strobes come from the demodulator
// Notes: Status register is read-only; writes to it do not exist on this port
`timescale 1ns/1ps
module rslq_top (
    input wire logic I_CLOCK,
    input wire logic I_RESET_N,
    input wire logic I_RX_STATE,
    input wire logic signed [7:0] I_POWER_DBM,
    input wire logic I_ED_START,
    input wire logic I_FRAME_START,
    input wire logic I_CORR_VALID,
    input wire logic [7:0] I_CORR_VALUE,
    input wire logic I_FRAME_END,
    input wire logic I_FCS_OK,
    input wire logic [6:0] I_PSDU_LEN,
    input wire logic I_REG_RD,
    input wire logic [5:0] I_REG_ADDR,
    output logic [7:0] O_REG_RDATA,
    output logic O_REG_RVALID,
    output logic [7:0] O_ED_LEVEL,
    output logic O_ED_DONE,
    output logic O_FB_WE,
    output logic [6:0] O_FB_ADDR,
    output logic [7:0] O_FB_WDATA,
    output logic O_FRAME_DONE_IRQ
);
    typedef enum logic [1:0] {
        FS_IDLE,
        FS_WAIT,
        FS_WRITE
    } rslq_fstate_t;

    typedef struct packed {
        logic [rslq_pkg::REFRESH_W-1:0] refresh_cnt;
        logic [4:0] code;
        logic crc_valid;
        logic ed_busy;
        logic [rslq_pkg::ED_CNT_W-1:0] ed_cnt;
        logic [2:0] ed_idx;
        logic [7:0] ed_sum;
        logic [7:0] ed_level;
        logic ed_done;
        rslq_fstate_t fstate;
        logic [6:0] len;
        logic fcs_ok;
        logic fb_we;
        logic [6:0] fb_addr;
        logic [7:0] fb_wdata;
        logic irq;
        logic [7:0] rdata;
        logic rvalid;
    } rslq_st_t;

    localparam logic [rslq_pkg::REFRESH_W-1:0] REFRESH_LAST =
        rslq_pkg::REFRESH_W'(rslq_pkg::REFRESH_CYC - 1);
    localparam logic [rslq_pkg::ED_CNT_W-1:0] ED_LAST =
        rslq_pkg::ED_CNT_W'(rslq_pkg::ED_SAMPLE_CYC - 1);

    rslq_st_t st_reg;
    rslq_st_t st_next;
    rslq_lqi_if lif ();
    logic refresh_tick;
    logic [7:0] status_word;

    rslq_lqi u_lqi (
        .i_clock(I_CLOCK),
        .i_reset_n(I_RESET_N),
        .lif(lif)
    );

    assign lif.frame_start = I_FRAME_START;
    assign lif.frame_end = I_FRAME_END;
    assign lif.corr_valid = I_CORR_VALID;
    assign lif.corr = I_CORR_VALUE;
    assign lif.len = I_PSDU_LEN;

    assign refresh_tick = I_RX_STATE && (st_reg.refresh_cnt == REFRESH_LAST);
    // Reserved bits 6:5 forced to zero
    assign status_word = {st_reg.crc_valid, 2'b00, st_reg.code};

    always_comb begin
        st_next = st_reg;
        st_next.ed_done = 1'b0;
        st_next.fb_we = 1'b0;
        st_next.irq = 1'b0;
        st_next.rvalid = 1'b0;

        // Code is held outside receive states; only refreshed while receiving
        if (!I_RX_STATE) begin
            st_next.refresh_cnt = '0;
        end else if (refresh_tick) begin
            st_next.refresh_cnt = '0;
            st_next.code = rslq_pkg::strength_code(I_POWER_DBM);
        end else begin
            st_next.refresh_cnt = rslq_pkg::REFRESH_W'(st_reg.refresh_cnt + 1'b1);
        end

        // Eight code samples, one per symbol, averaged and scaled to dB
        if (!I_RX_STATE) begin
            st_next.ed_busy = 1'b0;
            st_next.ed_level = 8'h00;
        end else if (I_ED_START) begin
            st_next.ed_busy = 1'b1;
            st_next.ed_cnt = '0;
            st_next.ed_idx = 3'h0;
            st_next.ed_sum = 8'h00;
        end else if (st_reg.ed_busy) begin
            if (st_reg.ed_cnt == ED_LAST) begin
                st_next.ed_cnt = '0;
                st_next.ed_sum = 8'(st_reg.ed_sum + 8'(st_reg.code));
                st_next.ed_idx = 3'(st_reg.ed_idx + 3'h1);
                if (st_reg.ed_idx == 3'(rslq_pkg::ED_SAMPLES - 1)) begin
                    st_next.ed_busy = 1'b0;
                    // Result and done pulse leave on the edge that sums the eighth sample
                    st_next.ed_done = 1'b1;
                    st_next.ed_level = 8'((st_next.ed_sum >> rslq_pkg::ED_AVG_SHIFT) *
                        rslq_pkg::ED_DB_PER_CODE);
                end
            end else begin
                st_next.ed_cnt = rslq_pkg::ED_CNT_W'(st_reg.ed_cnt + 1'b1);
            end
        end

        case (st_reg.fstate)
            FS_IDLE: begin
                if (I_FRAME_END) begin
                    st_next.len = I_PSDU_LEN;
                    st_next.fcs_ok = I_FCS_OK;
                    st_next.fstate = FS_WAIT;
                end
            end
            FS_WAIT: begin
                if (lif.done) begin
                    st_next.fb_we = 1'b1;
                    st_next.fb_addr = st_reg.len;
                    st_next.fb_wdata = lif.lqi;
                    st_next.fstate = FS_WRITE;
                end
            end
            FS_WRITE: begin
                // Interrupt follows the buffer write so the byte is already there
                st_next.irq = 1'b1;
                st_next.crc_valid = st_reg.fcs_ok;
                st_next.fstate = FS_IDLE;
            end
            default: begin
                st_next.fstate = FS_IDLE;
            end
        endcase

        if (I_REG_RD) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = (I_REG_ADDR == rslq_pkg::STATUS_OFFSET) ? status_word : 8'h00;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RESET_N) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign O_REG_RDATA = st_reg.rdata;
    assign O_REG_RVALID = st_reg.rvalid;
    assign O_ED_LEVEL = st_reg.ed_level;
    assign O_ED_DONE = st_reg.ed_done;
    assign O_FB_WE = st_reg.fb_we;
    assign O_FB_ADDR = st_reg.fb_addr;
    assign O_FB_WDATA = st_reg.fb_wdata;
    assign O_FRAME_DONE_IRQ = st_reg.irq;

    // Helper: cycles since the previous refresh
    logic [rslq_pkg::REFRESH_W-1:0] gap_cnt;
    always_ff @(posedge I_CLOCK) begin
        if (!I_RESET_N || !I_RX_STATE || refresh_tick) begin
            gap_cnt <= '0;
        end else begin
            gap_cnt <= rslq_pkg::REFRESH_W'(gap_cnt + 1'b1);
        end
    end

    a_code_range: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
        st_reg.code <= 5'h1C)
        else $error("strength code above 28");
    a_code_floor: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
        (refresh_tick && I_POWER_DBM < -8'sd91) |=> st_reg.code == 5'h00)
        else $error("power below floor not coded zero");
    a_code_top: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
        (refresh_tick && I_POWER_DBM >= -8'sd10) |=> st_reg.code == 5'h1C)
        else $error("power at top not coded 28");
    a_code_step: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
        (refresh_tick && I_POWER_DBM == -8'sd88) |=> st_reg.code == 5'h02)
        else $error("3 dB step mapping wrong");
    a_refresh_gap: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
        (refresh_tick && $past(I_RX_STATE)) |-> gap_cnt == 8'd199)
        else $error("strength refresh period not 2 us");
    a_status_read: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
        (I_REG_RD && I_REG_ADDR == 6'h06) |=>
        (O_REG_RVALID && O_REG_RDATA[6:5] == 2'b00 && O_REG_RDATA[4:0] == $past(st_reg.code)))
        else $error("status read data wrong");
    a_crc_hold: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
        !O_FRAME_DONE_IRQ |-> $stable(st_reg.crc_valid))
        else $error("frame check flag changed without interrupt");
    a_lqi_append: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
        (st_reg.fstate == FS_IDLE && I_FRAME_END) ##1 (lif.done && !I_FRAME_END)
        |=> (O_FB_WE && O_FB_ADDR == $past(st_reg.len)) ##1 O_FRAME_DONE_IRQ)
        else $error("link quality byte not appended before interrupt");
    a_ed_range: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
        O_ED_LEVEL <= 8'd84)
        else $error("energy level above 84");

    c_refresh: cover property (@(posedge I_CLOCK) disable iff (!I_RESET_N) refresh_tick);
    c_frame_irq: cover property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
        O_FRAME_DONE_IRQ && st_reg.crc_valid);
    c_ed_done: cover property (@(posedge I_CLOCK) disable iff (!I_RESET_N) O_ED_DONE);
endmodule // rslq_top

// ===== tb/rslq_host.sv
// Purpose: Host side model that reads the status register and collects frame buffer bytes
// Assumes: Basic operating mode; requests change just after the falling clock edge
// Notes: The appended quality byte is only taken once the frame done pulse is seen
`timescale 1ns/1ps
module rslq_host (
    input wire logic i_clock,
    input wire logic i_fb_we,
    input wire logic [6:0] i_fb_addr,
    input wire logic [7:0] i_fb_wdata,
    input wire logic i_irq,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output logic o_reg_rd,
    output logic [5:0] o_reg_addr
);
    logic [7:0] fb_mem [0:127];
    logic [6:0] last_addr;
    logic [7:0] lqi_seen;

    initial begin
        o_reg_rd = 1'b0;
        o_reg_addr = 6'h00;
        last_addr = 7'h00;
        lqi_seen = 8'h00;
    end

    always @(posedge i_clock) begin
        if (i_fb_we) begin
            fb_mem[i_fb_addr] <= i_fb_wdata;
            last_addr <= i_fb_addr;
        end
        // Fetching earlier could pick up a byte from the previous frame
        if (i_irq) begin
            lqi_seen <= fb_mem[last_addr];
        end
    end

    // Strength code is read in basic mode only; extended mode is never used here
    task automatic read_reg(input logic [5:0] addr, output logic [7:0] data, output logic ok);
        @(negedge i_clock);
        o_reg_rd = 1'b1;
        o_reg_addr = addr;
        // Answer stands for one cycle after the taking edge; sample it mid-cycle
        @(negedge i_clock);
        o_reg_rd = 1'b0;
        ok = i_rvalid;
        data = i_rdata;
    endtask
endmodule // rslq_host

// ===== tb/rslq_top_tb.sv
// Purpose: Self-checking bench for strength code, status register, quality byte and energy
// Assumes: Inputs change on the falling edge; reset held 20 cycles
// Notes: Expected values are worked out here from the power and correlation inputs
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module rslq_top_tb;
    logic clk = 1'b0, rst_n = 1'b0, rx = 1'b0, ed_start = 1'b0, f_start = 1'b0;
    logic c_valid = 1'b0, f_end = 1'b0, fcs = 1'b0, rd, rvalid, ok;
    logic signed [7:0] pwr = 8'sh00;
    logic [7:0] c_val = 8'h00, rdata, ed_level, fb_wdata, d;
    logic [6:0] len = 7'h00, fb_addr;
    logic [5:0] addr;
    logic ed_done, fb_we, irq;
    logic [4:0] cur_code = 5'h00;
    int fails = 0, checks_done = 0, cycles = 0, n;
    int pw_tab[9] = '{-128, -92, -91, -89, -88, -50, -11, -10, 3};

    always #5 clk = ~clk;

    rslq_top rslq_top_inst (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_RX_STATE(rx),
        .I_POWER_DBM(pwr), .I_ED_START(ed_start), .I_FRAME_START(f_start),
        .I_CORR_VALID(c_valid), .I_CORR_VALUE(c_val), .I_FRAME_END(f_end), .I_FCS_OK(fcs),
        .I_PSDU_LEN(len), .I_REG_RD(rd), .I_REG_ADDR(addr), .O_REG_RDATA(rdata),
        .O_REG_RVALID(rvalid), .O_ED_LEVEL(ed_level), .O_ED_DONE(ed_done), .O_FB_WE(fb_we),
        .O_FB_ADDR(fb_addr), .O_FB_WDATA(fb_wdata), .O_FRAME_DONE_IRQ(irq));

    rslq_host rslq_host_inst (.i_clock(clk), .i_fb_we(fb_we), .i_fb_addr(fb_addr),
        .i_fb_wdata(fb_wdata), .i_irq(irq), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_reg_rd(rd), .o_reg_addr(addr));

    function automatic logic [4:0] exp_code(input int p);
        if (p < -91) return 5'h00;
        if (p >= -10) return 5'h1C;
        return 5'((p + 91) / 3 + 1);
    endfunction

    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_status(input logic crc);
        rslq_host_inst.read_reg(6'h06, d, ok);
        `CHK(ok, 1'b1)
        `CHK(d, {crc, 2'b00, cur_code})
    endtask

    // Constant correlation keeps the running average equal to that value
    task automatic send_frame(input logic [7:0] cv, input logic [6:0] ln, input logic ok_fcs);
        logic [7:0] exp_lqi;
        exp_lqi = (ln < 7'h02) ? 8'h00 : cv;
        @(negedge clk) f_start = 1'b1;
        @(negedge clk) f_start = 1'b0;
        // First symbol directly follows the start strobe so seeding is exercised
        repeat (10) begin
            c_valid = 1'b1;
            c_val = cv;
            @(negedge clk) c_valid = 1'b0;
            @(negedge clk);
        end
        @(negedge clk) f_end = 1'b1;
        fcs = ok_fcs;
        len = ln;
        @(negedge clk) f_end = 1'b0;
        `CHK(fb_we, 1'b0)
        @(negedge clk) `CHK(fb_we, 1'b1)
        `CHK(fb_addr, ln)
        `CHK(fb_wdata, exp_lqi)
        @(negedge clk) `CHK(irq, 1'b1)
        @(negedge clk) `CHK(rslq_host_inst.lqi_seen, exp_lqi)
        chk_status(ok_fcs);
        $display("frame test done, lqi %h", exp_lqi);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            close_out();
        end
    end

    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        chk_status(1'b0);
        rslq_host_inst.read_reg(6'h3F, d, ok);
        `CHK(d, 8'h00)
        $display("reset test done");
        rx = 1'b1;
        foreach (pw_tab[i]) begin
            @(negedge clk) pwr = 8'(pw_tab[i]);
            cur_code = exp_code(pw_tab[i]);
            repeat (205) @(negedge clk);
            chk_status(1'b0);
        end
        $display("mapping test done");
        @(negedge clk) rx = 1'b0;
        pwr = -8'sd91;
        repeat (300) @(negedge clk);
        chk_status(1'b0);
        rx = 1'b1;
        repeat (188) @(negedge clk);
        chk_status(1'b0);
        repeat (20) @(negedge clk);
        cur_code = 5'h01;
        chk_status(1'b0);
        $display("refresh test done");
        send_frame(8'hFF, 7'h0A, 1'b1);
        send_frame(8'h80, 7'h01, 1'b0);
        send_frame(8'h00, 7'h02, 1'b1);
        @(negedge clk) pwr = -8'sd50;
        repeat (205) @(negedge clk);
        ed_start = 1'b1;
        @(negedge clk) ed_start = 1'b0;
        n = 1;
        while (ed_done !== 1'b1 && n < 13500) begin
            @(negedge clk) n++;
        end
        `CHK(n > 12790 && n < 12810, 1'b1)
        `CHK(ed_level, 8'h2A)
        @(negedge clk) rx = 1'b0;
        repeat (3) @(negedge clk);
        `CHK(ed_level, 8'h00)
        $display("energy test done");
        close_out();
    end
endmodule // rslq_top_tb
